// ### itd_mem_model.sv
// Program memory and internal data memory model.
// Assumes the bench fills codeMem before each fetch.
`timescale 1ns/10ps
`default_nettype none
module itd_mem_model
    import itd_pkg::*;
(
    input wire logic [15:0] instrAddr,
    input wire logic [1:0] bankSelectField,
    output logic [7:0] opcode,
    output logic [7:0] operand1,
    output logic [7:0] operand2,
    output logic [7:0] pointerValue
);
    logic [7:0] codeMem [0:255];
    logic [7:0] dataRam [0:31];
    assign opcode = codeMem[instrAddr[7:0]];
    assign operand1 = codeMem[instrAddr[7:0] + 8'h01];
    assign operand2 = codeMem[instrAddr[7:0] + 8'h02];
    // pointer from bank register 0 or 1
    assign pointerValue = dataRam[{bankSelectField, 2'h0, opcode[0]}];
    initial begin
        for (int i = 0; i < 256; i++) begin
            codeMem[i] = 8'h00;
        end
        for (int i = 0; i < 32; i++) begin
            dataRam[i] = 8'(i) + 8'h40;
        end
    end
endmodule : itd_mem_model
`default_nettype wire

// ### itd_opcode_table.sv
// Opcode table: byte length, cycle costs, class and condition.
// Assumes the opcode byte is stable for the decode cycle.
`timescale 1ns/10ps
`default_nettype none
module itd_opcode_table
    import itd_pkg::*;
(
    input wire logic [7:0] opcode,
    output itd_dec_t dec
);
    always_comb begin
        dec = '{length: 2'd1, baseCycles: 4'h1, takenCycles: 4'h1,
                cls: ITD_CLS_PLAIN, cond: ITD_CND_CARRY,
                clearBit: 1'b0, pushOp: 1'b0};
        casez (opcode)
            8'h00, 8'ha5: dec.baseCycles = 4'h1;
            8'he4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4: dec.baseCycles = 4'h1;
            8'hf4: dec.baseCycles = 4'h2;
            8'b1110_1???: dec.baseCycles = 4'h1;
            8'he5: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h2;
            end
            8'he6, 8'he7: dec.baseCycles = 4'h2;
            8'h90, 8'h85, 8'h75: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h3;
            end
            8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3:
                dec.baseCycles = 4'h3;
            8'h93: begin
                dec.baseCycles = 4'h4;
                dec.cls = ITD_CLS_CODE_SIXTEEN_BIT_POINTER;
            end
            8'h83: dec.baseCycles = 4'h3;
            8'hc0, 8'hd0: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h2;
                dec.pushOp = (opcode == 8'hc0);
            end
            8'hd6, 8'hd7: dec.baseCycles = 4'h2;
            8'hc3, 8'hd3, 8'hb3: dec.baseCycles = 4'h1;
            8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2,
            8'h92: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h2;
            end
            8'h40, 8'h50, 8'h60, 8'h70: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h2;
                dec.takenCycles = 4'h4;
                dec.cls = ITD_CLS_COND;
                dec.cond = opcode[5] ? (opcode[4] ? ITD_CND_ACCNZ
                    : ITD_CND_ACCZ) : (opcode[4] ? ITD_CND_NOCARRY
                    : ITD_CND_CARRY);
            end
            8'h10, 8'h20, 8'h30: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h3;
                dec.takenCycles = 4'h5;
                dec.cls = ITD_CLS_COND;
                dec.cond = (opcode == 8'h30) ? ITD_CND_BITCLR
                    : ITD_CND_BITSET;
                dec.clearBit = (opcode == 8'h10);
            end
            8'b???0_0001, 8'b???1_0001: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h4;
                dec.cls = opcode[4] ? ITD_CLS_PAGE_CALL : ITD_CLS_PAGE_JMP;
            end
            8'h02, 8'h12: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h5;
                dec.cls = opcode[4] ? ITD_CLS_FAR_CALL : ITD_CLS_FAR_JMP;
            end
            8'h22, 8'h32: begin
                dec.baseCycles = 4'h6;
                dec.cls = ITD_CLS_RET;
            end
            8'h80: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h4;
                dec.cls = ITD_CLS_NEAR_JMP;
            end
            8'h73: begin
                dec.baseCycles = 4'h3;
                dec.cls = ITD_CLS_IND_JMP;
            end
            8'hb5, 8'hb6, 8'hb7: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h4;
                dec.takenCycles = 4'h6;
                dec.cls = ITD_CLS_COND;
                dec.cond = ITD_CND_UNEQUAL;
            end
            8'hb4: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h3;
                dec.takenCycles = 4'h6;
                dec.cls = ITD_CLS_COND;
                dec.cond = ITD_CND_UNEQUAL;
            end
            8'b1011_1???: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h3;
                dec.takenCycles = 4'h5;
                dec.cls = ITD_CLS_COND;
                dec.cond = ITD_CND_UNEQUAL;
            end
            8'b1101_1???: begin
                dec.length = 2'd2;
                dec.baseCycles = 4'h2;
                dec.takenCycles = 4'h4;
                dec.cls = ITD_CLS_COND;
                dec.cond = ITD_CND_NONZERO;
            end
            8'hd5: begin
                dec.length = 2'd3;
                dec.baseCycles = 4'h3;
                dec.takenCycles = 4'h5;
                dec.cls = ITD_CLS_COND;
                dec.cond = ITD_CND_NONZERO;
            end
            default: begin
                dec.length = 2'd1;
                dec.baseCycles = 4'h1;
            end
        endcase
    end
endmodule : itd_opcode_table
`default_nettype wire

// ### itd_operand_addr.sv
// Operand address resolution: bank registers, indirect pointers, direct.
// Assumes the bank select field comes from the status word.
`timescale 1ns/10ps
`default_nettype none
module itd_operand_addr
    import itd_pkg::*;
(
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand,
    input wire logic [1:0] bankSelectField,
    input wire logic [7:0] pointerValue,
    output itd_opnd_t opnd,
    output logic [7:0] bankRegAddr
);
    always_comb begin
        bankRegAddr = {3'h0, bankSelectField, opcode[2:0]};
        opnd.addr = operand;
        opnd.isSfr = 1'b0;
        if (opcode[3]) begin
            opnd.addr = bankRegAddr;
        end else if (opcode[2:1] == 2'b11) begin
            opnd.addr = pointerValue;
        end else begin
            opnd.isSfr = (operand >= ITD_SFR_BASE);
        end
    end
endmodule : itd_operand_addr
`default_nettype wire

// ### itd_pkg.sv
// Package for the instruction timing decoder: opcode classes, timing and
// addressing constants, decode result carrier.
// Assumes a single 200 MHz system clock and synchronous active-low reset.
package itd_pkg;

    // ****************************************************************
    // Addressing constants
    // ****************************************************************
    localparam logic [7:0] ITD_SFR_BASE = 8'h80;
    localparam logic [7:0] ITD_SP_RESET = 8'h07;
    localparam logic [7:0] ITD_NOP_OP = 8'h00;
    localparam logic [7:0] ITD_SPARE_OP = 8'ha5;
    localparam int ITD_BANK_LSB = 3;
    localparam int ITD_PAGE_BITS = 11;

    // ****************************************************************
    // Timing constants
    // ****************************************************************
    localparam logic [3:0] ITD_ALIGN_MAX = 4'h2;
    localparam logic [1:0] ITD_WAIT_RESET = 2'h0;

    // ****************************************************************
    // Instruction classes
    // ****************************************************************
    typedef enum logic [3:0] {
        ITD_CLS_PLAIN = 4'h0,
        ITD_CLS_CODE_SIXTEEN_BIT_POINTER = 4'h1,
        ITD_CLS_COND = 4'h2,
        ITD_CLS_PAGE_JMP = 4'h3,
        ITD_CLS_PAGE_CALL = 4'h4,
        ITD_CLS_FAR_JMP = 4'h5,
        ITD_CLS_FAR_CALL = 4'h6,
        ITD_CLS_RET = 4'h7,
        ITD_CLS_NEAR_JMP = 4'h8,
        ITD_CLS_IND_JMP = 4'h9
    } itd_cls_t;

    typedef enum logic [2:0] {
        ITD_CND_CARRY = 3'h0,
        ITD_CND_NOCARRY = 3'h1,
        ITD_CND_ACCZ = 3'h2,
        ITD_CND_ACCNZ = 3'h3,
        ITD_CND_BITSET = 3'h4,
        ITD_CND_BITCLR = 3'h5,
        ITD_CND_UNEQUAL = 3'h6,
        ITD_CND_NONZERO = 3'h7
    } itd_cond_t;

    // Decode result
    typedef struct packed {
        logic [1:0] length;
        logic [3:0] baseCycles;
        logic [3:0] takenCycles;
        itd_cls_t cls;
        itd_cond_t cond;
        logic clearBit;
        logic pushOp;
    } itd_dec_t;

    // Operand address result
    typedef struct packed {
        logic [7:0] addr;
        logic isSfr;
    } itd_opnd_t;

endpackage : itd_pkg

// ### itd_timing_decode.sv
// Instruction timing decoder: byte length, cycle count, branch targets.
// Assumes opcode and operand bytes arrive with instrValid for one cycle.
// What this block does
// - Some instruction cycle counts vary with alignment and wait setting.
// - Bank register to accumulator 1 cycle; direct or indirect 2 cycles.
// - External data moves are one byte, three cycles.
// - Code read via pointer 4-7 cycles; via program counter 3.
// - Carry and accumulator jumps: 2 not taken, 4-6 taken.
// - Bit jumps: 3 not taken, 5-7 taken; clear variant clears bit.
// - Page call 4-6 cycles; far call 5-7 cycles.
// - Subroutine and interrupt returns take 6-8 cycles.
// - Near, page jumps 4-6; far jump 5-7; indirect jump 3-5.
// - Compare-jump costs per operand form, not taken versus taken.
// - Decrement-jump: register 2 or 4-6; direct 3 or 5-7.
// - Relative offsets signed 8-bit from next instruction address.
// - Direct address low half RAM, upper half special registers.
// - Page target replaces low 11 bits within the 2 kB page.
// - Far target reaches all of 64 kB.
// - Spare opcode acts as one-byte one-cycle no-op.
// - Eight bank registers; indirect uses register 0 or 1.
// - Carry ops 1 cycle; direct bit ops two bytes, two cycles.
// - Accumulator clear, rotate, swap 1 cycle; complement 2.
// - Pointer load and direct moves three bytes, three cycles.
// - Push, pop 2 cycles; nibble exchange one byte, 2 cycles.
// - Bank select maps banks 0-3 to eight-byte windows from zero.
// - Stack pointer increments before push and resets to 7.
`timescale 1ns/10ps
`default_nettype none
module itd_timing_decode
    import itd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [15:0] instrAddr,
    input wire logic [7:0] accValue,
    input wire logic carryFlag,
    input wire logic testBit,
    input wire logic [1:0] bankSelectField,
    input wire logic [7:0] pointerValue,
    input wire logic [7:0] compareValue,
    input wire logic [7:0] counterValue,
    input wire logic [15:0] indirectTarget,
    input wire logic [15:0] returnTarget,
    input wire logic [1:0] flashReadWaitSetting,
    output logic busy,
    output logic done,
    output logic [1:0] byteLength_q,
    output logic [3:0] cycleCount_q,
    output logic branchTaken_q,
    output logic [15:0] nextPc_q,
    output logic clearTestBit_q,
    output logic [7:0] operandAddr_q,
    output logic operandIsSfr_q,
    output logic [7:0] bankRegAddr_q,
    output logic [7:0] stackTopPointer_q
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // signed offset add
    function automatic logic [15:0] relTarget(input logic [15:0] base,
                                              input logic [7:0] rel);
        relTarget = base + {{8{rel[7]}}, rel};
    endfunction : relTarget

    function automatic logic [3:0] penalty(input logic [15:0] target,
                                           input logic [1:0] waitSet);
        logic [3:0] p;
        p = {2'h0, waitSet} + {3'h0, target[0]};
        penalty = (p > ITD_ALIGN_MAX) ? ITD_ALIGN_MAX : p;
    endfunction : penalty

    // ****************************************************************
    // Decode
    // ****************************************************************
    itd_dec_t dec;
    itd_opnd_t opnd;
    logic [7:0] bankRegAddr;

    itd_opcode_table uTable (
        .opcode(opcode),
        .dec(dec)
    );

    itd_operand_addr uOpnd (
        .opcode(opcode),
        .operand(operand1),
        .bankSelectField(bankSelectField),
        .pointerValue(pointerValue),
        .opnd(opnd),
        .bankRegAddr(bankRegAddr)
    );

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [0:0] {
        ITD_IDLE = 1'b0,
        ITD_EXEC = 1'b1
    } itd_state_t;

    itd_state_t state_q;
    itd_state_t state_d;
    logic [3:0] remain_q;
    logic [3:0] remain_d;
    logic [1:0] byteLength_d;
    logic [3:0] cycleCount_d;
    logic branchTaken_d;
    logic [15:0] nextPc_d;
    logic clearTestBit_d;
    logic [7:0] operandAddr_d;
    logic operandIsSfr_d;
    logic [7:0] bankRegAddr_d;
    logic [7:0] stackTopPointer_d;
    logic [15:0] fallPc;
    logic [15:0] target;
    logic taken;
    logic [3:0] cost;

    // ****************************************************************
    // Target and condition
    // ****************************************************************
    always_comb begin
        fallPc = instrAddr + {14'h0, dec.length};
        target = fallPc;
        taken = 1'b0;
        case (dec.cls)
            ITD_CLS_COND: begin
                case (dec.cond)
                    ITD_CND_CARRY: taken = carryFlag;
                    ITD_CND_NOCARRY: taken = !carryFlag;
                    ITD_CND_ACCZ: taken = (accValue == 8'h00);
                    ITD_CND_ACCNZ: taken = (accValue != 8'h00);
                    ITD_CND_BITSET: taken = testBit;
                    ITD_CND_BITCLR: taken = !testBit;
                    ITD_CND_UNEQUAL: taken = (compareValue != operand1);
                    ITD_CND_NONZERO: taken = ((counterValue - 8'h01) != 8'h00);
                    default: taken = 1'b0;
                endcase
                target = relTarget(fallPc, (dec.length == 2'd3)
                    ? operand2 : operand1);
            end
            ITD_CLS_NEAR_JMP: begin
                taken = 1'b1;
                target = relTarget(fallPc, operand1);
            end
            ITD_CLS_PAGE_JMP, ITD_CLS_PAGE_CALL: begin
                taken = 1'b1;
                target = {fallPc[15:ITD_PAGE_BITS], opcode[7:5], operand1};
            end
            ITD_CLS_FAR_JMP, ITD_CLS_FAR_CALL: begin
                taken = 1'b1;
                target = {operand1, operand2};
            end
            ITD_CLS_RET: begin
                taken = 1'b1;
                target = returnTarget;
            end
            ITD_CLS_IND_JMP: begin
                taken = 1'b1;
                target = indirectTarget;
            end
            default: begin
                taken = 1'b0;
                target = fallPc;
            end
        endcase
        if (dec.cls == ITD_CLS_COND) begin
            cost = taken ? dec.takenCycles
                + penalty(target, flashReadWaitSetting) : dec.baseCycles;
        end else if (taken || dec.cls == ITD_CLS_CODE_SIXTEEN_BIT_POINTER) begin
            cost = dec.baseCycles + penalty(target, flashReadWaitSetting)
                + ((dec.cls == ITD_CLS_CODE_SIXTEEN_BIT_POINTER)
                ? {3'h0, flashReadWaitSetting == 2'h3} : 4'h0);
        end else begin
            cost = dec.baseCycles;
        end
    end

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        remain_d = remain_q;
        byteLength_d = byteLength_q;
        cycleCount_d = cycleCount_q;
        branchTaken_d = branchTaken_q;
        nextPc_d = nextPc_q;
        clearTestBit_d = 1'b0;
        operandAddr_d = operandAddr_q;
        operandIsSfr_d = operandIsSfr_q;
        bankRegAddr_d = bankRegAddr_q;
        stackTopPointer_d = stackTopPointer_q;
        case (state_q)
            ITD_IDLE: begin
                if (instrValid) begin
                    byteLength_d = dec.length;
                    cycleCount_d = cost;
                    branchTaken_d = taken;
                    nextPc_d = taken ? target : fallPc;
                    clearTestBit_d = dec.clearBit && taken;
                    operandAddr_d = opnd.addr;
                    operandIsSfr_d = opnd.isSfr;
                    bankRegAddr_d = bankRegAddr;
                    if (dec.pushOp || dec.cls == ITD_CLS_PAGE_CALL
                        || dec.cls == ITD_CLS_FAR_CALL) begin
                        stackTopPointer_d = stackTopPointer_q
                            + ((dec.pushOp) ? 8'h01 : 8'h02);
                    end else if (opcode == 8'hd0) begin
                        stackTopPointer_d = stackTopPointer_q - 8'h01;
                    end else if (dec.cls == ITD_CLS_RET) begin
                        stackTopPointer_d = stackTopPointer_q - 8'h02;
                    end
                    remain_d = cost - 4'h1;
                    state_d = (cost == 4'h1) ? ITD_IDLE : ITD_EXEC;
                end
            end
            ITD_EXEC: begin
                remain_d = remain_q - 4'h1;
                if (remain_q == 4'h1) begin
                    state_d = ITD_IDLE;
                end
            end
            default: state_d = ITD_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ITD_IDLE;
            remain_q <= 4'h0;
            byteLength_q <= 2'h0;
            cycleCount_q <= 4'h0;
            branchTaken_q <= 1'b0;
            nextPc_q <= 16'h0000;
            clearTestBit_q <= 1'b0;
            operandAddr_q <= 8'h00;
            operandIsSfr_q <= 1'b0;
            bankRegAddr_q <= 8'h00;
            stackTopPointer_q <= ITD_SP_RESET;
        end else begin
            state_q <= state_d;
            remain_q <= remain_d;
            byteLength_q <= byteLength_d;
            cycleCount_q <= cycleCount_d;
            branchTaken_q <= branchTaken_d;
            nextPc_q <= nextPc_d;
            clearTestBit_q <= clearTestBit_d;
            operandAddr_q <= operandAddr_d;
            operandIsSfr_q <= operandIsSfr_d;
            bankRegAddr_q <= bankRegAddr_d;
            stackTopPointer_q <= stackTopPointer_d;
        end
    end

    // Busy while cycles remain; done on last cycle
    assign busy = (state_q == ITD_EXEC);
    assign done = (state_q == ITD_EXEC) ? (remain_q == 4'h1)
        : (instrValid && cost == 4'h1);

endmodule : itd_timing_decode
`default_nettype wire

// ### itd_timing_decode_sva.sv
// Checker for the instruction timing decoder ports.
// Assumes it is bound onto itd_timing_decode; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module itd_timing_decode_sva
    import itd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [15:0] instrAddr,
    input wire logic carryFlag,
    input wire logic [1:0] bankSelectField,
    input wire logic busy,
    input wire logic done,
    input wire logic [1:0] byteLength_q,
    input wire logic [3:0] cycleCount_q,
    input wire logic branchTaken_q,
    input wire logic [15:0] nextPc_q,
    input wire logic clearTestBit_q,
    input wire logic [7:0] operandAddr_q,
    input wire logic operandIsSfr_q,
    input wire logic [7:0] bankRegAddr_q
);
    logic take;
    logic [15:0] seqPc;
    logic [15:0] nearTgt;
    logic [15:0] pageTgt;
    assign take = instrValid && !busy;
    assign seqPc = instrAddr + 16'h0002;
    assign nearTgt = seqPc + {{8{operand1[7]}}, operand1};
    assign pageTgt = {seqPc[15:11], opcode[7:5], operand1};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // Timing, targets and operands
    // ****************************************************************
    a_busy_hold: assert property (
        busy |=> $stable(nextPc_q) && $stable(cycleCount_q))
        else $error("results changed while busy");
    a_done_bound: assert property (
        busy |-> ##[0:8] done) else $error("done late");
    a_spare_nop: assert property (
        take && opcode == ITD_SPARE_OP |=> byteLength_q == 2'h1
        && cycleCount_q == 4'h1 && nextPc_q == $past(instrAddr) + 16'h0001)
        else $error("spare opcode wrong");
    a_near_target: assert property (
        take && opcode == 8'h80 |=> nextPc_q == $past(nearTgt))
        else $error("near target wrong");
    a_page_target: assert property (
        take && opcode[3:0] == 4'h1 |=> nextPc_q == $past(pageTgt))
        else $error("page target wrong");
    a_far_target: assert property (
        take && opcode[7:5] == 3'h0 && opcode[3:0] == 4'h2
        |=> nextPc_q[15:8] == $past(operand1)) else $error("far target wrong");
    a_sfr_split: assert property (
        take && opcode == 8'he5 |=> operandAddr_q == $past(operand1)
        && operandIsSfr_q == operandAddr_q[7]) else $error("direct split");
    a_bank_window: assert property (
        take && opcode[7:3] == 5'h1d |=> bankRegAddr_q == {3'h0,
        $past(bankSelectField), $past(opcode[2:0])}) else $error("bank addr");
    a_clear_pulse: assert property (
        clearTestBit_q |=> !clearTestBit_q) else $error("clear pulse long");
    a_ext_move: assert property (
        take && opcode == 8'he0 |=> cycleCount_q == 4'h3)
        else $error("external move cycles");
    a_carry_skip: assert property (
        take && opcode == 8'h50 && carryFlag |=> cycleCount_q == 4'h2
        && !branchTaken_q) else $error("untaken carry jump");
endmodule : itd_timing_decode_sva
bind itd_timing_decode itd_timing_decode_sva u_sva (.*);
`default_nettype wire

// ### itd_timing_decode_tb.sv
// Self-checking bench for the instruction timing decoder.
// Assumes the memory model supplies the fetched bytes.
`timescale 1ns/10ps
`default_nettype none
module itd_timing_decode_tb import itd_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n, instrValid, flag, clrSeen, busy, done;
    logic [7:0] opcode, operand1, operand2, pointerValue, accValue;
    logic [7:0] compareValue = 8'h55;
    logic [7:0] counterValue = 8'h01;
    logic [15:0] indirectTarget = 16'h0100;
    logic [15:0] returnTarget = 16'h2000;
    logic [15:0] instrAddr, nextPc_q;
    logic [1:0] bankSelectField, flashReadWaitSetting, byteLength_q;
    logic [3:0] cycleCount_q;
    logic branchTaken_q, clearTestBit_q, operandIsSfr_q;
    logic [7:0] operandAddr_q, bankRegAddr_q, stackTopPointer_q;
    logic [71:0] r;
    int errCount = 0;
    int checked = 0;
    // Rows: op, byte1, byte2, addr, flag, length, cycles, taken, next pc
    localparam logic [71:0] ROWS [38] = '{
        72'he8_0000_0100_0110_0101, 72'he5_3000_0100_0220_0102,
        72'he6_0000_0100_0120_0101, 72'he0_0000_0100_0130_0101,
        72'hf2_0000_0100_0130_0101, 72'h83_0000_0100_0130_0101,
        72'h93_0000_0100_0150_0101, 72'h40_0200_0100_1241_0104,
        72'h50_0200_0100_1220_0102, 72'h60_fe00_0100_1241_0100,
        72'h70_fe00_0100_1220_0102, 72'h20_0005_0100_1351_0108,
        72'h30_0005_0100_1330_0103, 72'h11_4000_0800_024f_0840,
        72'h12_1234_0100_035f_1234, 72'h22_0000_0100_016f_2000,
        72'h32_0000_0100_016f_2000, 72'h01_1000_0f00_024f_0810,
        72'h02_fffe_0100_035f_fffe, 72'h80_8000_0200_024f_0182,
        72'h73_0000_0100_013f_0100, 72'hb5_5501_0100_0340_0103,
        72'hb4_0001_0100_0361_0104, 72'hb8_0001_0100_0351_0104,
        72'hb6_0001_0100_0361_0104, 72'hd8_0200_0100_0220_0102,
        72'hd5_3002_0100_0330_0103, 72'ha5_0000_0100_011f_0101,
        72'hc3_0000_0100_011f_0101, 72'hb2_0000_0100_022f_0102,
        72'he4_0000_0100_011f_0101, 72'hf4_0000_0100_012f_0101,
        72'hc4_0000_0100_011f_0101, 72'h13_0000_0100_011f_0101,
        72'h90_0000_0100_033f_0103, 72'hc0_0000_0100_022f_0102,
        72'hd6_0000_0100_012f_0101, 72'h10_0005_0100_1351_0108};
    assign accValue = flag ? 8'h00 : 8'h01;
    itd_mem_model mdl (.*);
    itd_timing_decode dut (.carryFlag(flag), .testBit(flag), .*);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (clearTestBit_q === 1'b1) clrSeen <= 1'b1;
    end
    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20) errCount++;
    endtask : wait_idle
    task automatic issue(input logic [15:0] a, input logic [7:0] op,
                         input logic [7:0] b1, input logic [7:0] b2);
        mdl.codeMem[a[7:0]] = op;
        mdl.codeMem[a[7:0] + 8'h01] = b1;
        mdl.codeMem[a[7:0] + 8'h02] = b2;
        instrAddr = a;
        instrValid = 1'b1;
        @(negedge clk_sys);
        instrValid = 1'b0;
        wait_idle();
    endtask : issue
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        errCount++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        instrValid = 1'b0;
        flag = 1'b1;
        clrSeen = 1'b0;
        instrAddr = 16'h0100;
        bankSelectField = 2'h2;
        flashReadWaitSetting = 2'h0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            r = ROWS[i];
            flag = r[28];
            issue(r[47:32], r[71:64], r[63:56], r[55:48]);
            check("length", 16'(r[27:24]), 16'(byteLength_q));
            check("cycles", 16'(r[23:20]), 16'(cycleCount_q));
            if (r[19:16] != 4'hf)
                check("taken", 16'(r[16]), 16'(branchTaken_q));
            check("next pc", r[15:0], nextPc_q);
        end
        check("bit clear", 16'h0001, 16'(clrSeen));
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        check("stack", 16'h0007, 16'(stackTopPointer_q));
        issue(16'h0100, 8'hc0, 8'h30, 8'h00);
        check("stack", 16'h0008, 16'(stackTopPointer_q));
        bankSelectField = 2'h3;
        issue(16'h0100, 8'hed, 8'h00, 8'h00);
        check("bank reg", 16'h001d, 16'(bankRegAddr_q));
        issue(16'h0100, 8'he5, 8'h81, 8'h00);
        check("sfr", 16'h0001, 16'(operandIsSfr_q));
        issue(16'h0100, 8'he5, 8'h7f, 8'h00);
        check("sfr", 16'h0000, 16'(operandIsSfr_q));
        flag = 1'b1;
        flashReadWaitSetting = 2'h1;
        issue(16'h0100, 8'h40, 8'h02, 8'h00);
        check("cycles", 16'h0005, 16'(cycleCount_q));
        flashReadWaitSetting = 2'h3;
        issue(16'h0100, 8'h40, 8'h02, 8'h00);
        check("cycles", 16'h0006, 16'(cycleCount_q));
        issue(16'h0100, 8'h93, 8'h00, 8'h00);
        check("cycles", 16'h0007, 16'(cycleCount_q));
        flashReadWaitSetting = 2'h0;
        mdl.codeMem[8'h10] = 8'ha5;
        mdl.codeMem[8'h00] = 8'h12;
        mdl.codeMem[8'h01] = 8'h12;
        mdl.codeMem[8'h02] = 8'h34;
        instrAddr = 16'h0100;
        instrValid = 1'b1;
        @(negedge clk_sys);
        instrAddr = 16'h0110;
        @(negedge clk_sys);
        instrValid = 1'b0;
        wait_idle();
        check("next pc", 16'h1234, nextPc_q);
        complete_run();
    end
endmodule : itd_timing_decode_tb
`default_nettype wire
